// ==== hw/adc_serial_port.sv ====
// control and serial port of a multiplexed sampling converter
`include "adc_port_regs.svh"
`timescale 1ns/1ps
module adc_serial_port (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_conversion_start_pin,
    input wire logic i_sel_n,
    input wire logic i_sck,
    input wire logic i_sdi,
    input wire adc_port_pkg::result_t i_sample,
    output logic o_busy_n,
    output logic o_sdo,
    output logic o_sdo_oe,
    output logic o_acquiring,
    output adc_port_pkg::cfg_t o_cfg,
    output logic o_sample_take
);
    import adc_port_pkg::*;

    edge_if e();

    pin_sync u_sync (
        .i_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_pins({i_sdi, i_sel_n, i_conversion_start_pin, i_sck}),
        .e(e)
    );

    conv_state_e state_ff;
    conv_state_e nxt_state;
    logic [8:0] cnt_ff;
    logic [8:0] nxt_cnt;
    cfg_t in_sr_ff;
    cfg_t nxt_in_sr;
    cfg_t cfg_ff;
    cfg_t nxt_cfg;
    logic [3:0] in_cnt_ff;
    logic [3:0] nxt_in_cnt;
    result_t out_sr_ff;
    result_t nxt_out_sr;
    logic busy_n_ff;
    logic nxt_busy_n;
    logic sdo_ff;
    logic nxt_sdo;
    logic oe_ff;
    logic nxt_oe;
    logic acq_ff;
    logic nxt_acq;
    logic take_ff;
    logic nxt_take;
    logic sck_ok;
    logic rise_ok;
    logic fall_ok;
    logic conv_done;

    // a serial edge counts only inside a select window
    function automatic logic port_edge(input logic sel_n, input logic strobe);
        return !sel_n && strobe;
    endfunction

    // select gates every serial edge
    assign sck_ok = ~e.sel_n;
    assign rise_ok = port_edge(e.sel_n, e.sck_rise);
    assign fall_ok = port_edge(e.sel_n, e.sck_fall);
    assign conv_done = (state_ff == ST_CONV) && (cnt_ff == 9'((`CONV_CYCLES) - 1));

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE, ST_ACQ: begin
                if (e.start_rise) begin
                    nxt_state = ST_CONV;
                end else if (fall_ok && in_cnt_ff == 4'(`ACQ_EDGE)) begin
                    nxt_state = ST_ACQ;
                end
            end
            ST_CONV: begin
                // start edges fall through unused here
                if (conv_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // zero outside a conversion except the first cycle after one, so every start times a full span
    always_comb begin
        nxt_cnt = 9'h000;
        if (state_ff == ST_CONV) begin
            nxt_cnt = cnt_ff + 9'h001;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_ff <= 9'h000;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // status decodes the next state so it lands together with it
    always_comb begin
        nxt_busy_n = 1'b1;
        nxt_acq = 1'b0;
        nxt_take = 1'b0;
        case (nxt_state)
            ST_CONV: begin
                nxt_busy_n = 1'b0;
                nxt_take = (state_ff != ST_CONV);
            end
            ST_ACQ: begin
                nxt_acq = 1'b1;
            end
            default: begin
                nxt_busy_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            busy_n_ff <= 1'b1;
            acq_ff <= 1'b0;
            take_ff <= 1'b0;
        end else begin
            busy_n_ff <= nxt_busy_n;
            acq_ff <= nxt_acq;
            take_ff <= nxt_take;
        end
    end

    always_comb begin
        nxt_in_sr = in_sr_ff;
        nxt_in_cnt = in_cnt_ff;
        nxt_cfg = cfg_ff;
        if (e.sel_n) begin
            // deselect restarts word framing for the next access
            nxt_in_cnt = 4'h0;
        end else if (rise_ok && in_cnt_ff < 4'(`CFG_BITS)) begin
            nxt_in_sr = {in_sr_ff[6:0], e.sdi};
            nxt_in_cnt = in_cnt_ff + 4'h1;
            if (in_cnt_ff == 4'(`CFG_BITS - 1)) begin
                nxt_cfg = {in_sr_ff[6:0], e.sdi};
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            in_sr_ff <= 8'h00;
            in_cnt_ff <= 4'h0;
            cfg_ff <= 8'h00;
        end else begin
            in_sr_ff <= nxt_in_sr;
            in_cnt_ff <= nxt_in_cnt;
            cfg_ff <= nxt_cfg;
        end
    end

    // result loads regardless of select; the host may read it later
    always_comb begin
        nxt_out_sr = out_sr_ff;
        nxt_sdo = sdo_ff;
        nxt_oe = sck_ok;
        if (conv_done) begin
            // sample is raw two's complement from the SAR
            nxt_out_sr = i_sample;
            nxt_sdo = i_sample[`RESULT_BITS - 1];
        end else if (fall_ok) begin
            nxt_out_sr = {out_sr_ff[`RESULT_BITS - 2:0], 1'b0};
            nxt_sdo = out_sr_ff[`RESULT_BITS - 2];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            out_sr_ff <= 16'h0000;
            sdo_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else begin
            out_sr_ff <= nxt_out_sr;
            sdo_ff <= nxt_sdo;
            oe_ff <= nxt_oe;
        end
    end

    assign o_busy_n = busy_n_ff;
    assign o_sdo = sdo_ff;
    assign o_sdo_oe = oe_ff;
    assign o_acquiring = acq_ff;
    assign o_cfg = cfg_ff;
    assign o_sample_take = take_ff;
endmodule

// ==== hw/pin_sync.sv ====
// two-stage synchronisers and edge detectors for the serial pins
`timescale 1ns/1ps
module pin_sync (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [3:0] i_pins,
    edge_if.src e
);
    logic [3:0] s1_ff;
    logic [3:0] s2_ff;
    logic [3:0] s3_ff;
    logic [3:0] nxt_s1;
    logic [3:0] nxt_s2;
    logic [3:0] nxt_s3;
    always_comb begin
        nxt_s1 = i_pins;
        nxt_s2 = s1_ff;
        nxt_s3 = s2_ff;
    end
    // sel_n resets high so the port starts deselected
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s1_ff <= 4'h4;
            s2_ff <= 4'h4;
            s3_ff <= 4'h4;
        end else begin
            s1_ff <= nxt_s1;
            s2_ff <= nxt_s2;
            s3_ff <= nxt_s3;
        end
    end
    // bit0 sck, bit1 start, bit2 sel_n, bit3 sdi
    assign e.sck_rise = s2_ff[0] & ~s3_ff[0];
    assign e.sck_fall = ~s2_ff[0] & s3_ff[0];
    assign e.start_rise = s2_ff[1] & ~s3_ff[1];
    assign e.sel_n = s2_ff[2];
    assign e.sdi = s2_ff[3];
endmodule

// ==== inc/adc_port_pkg.sv ====
// types shared by the converter serial port
package adc_port_pkg;
    typedef logic [15:0] result_t;
    typedef logic [7:0] cfg_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACQ = 3'b010,
        ST_CONV = 3'b100
    } conv_state_e;
endpackage

// ==== inc/adc_port_regs.svh ====
// timing counts and field layout of the converter serial port
`ifndef ADC_PORT_REGS_SVH
`define ADC_PORT_REGS_SVH
`define CLK_PERIOD_NS 50
`define CONV_TIME_NS 5000
`define CONV_CYCLES (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define RESULT_BITS 16
`define CFG_BITS 8
`define ACQ_EDGE 6
`define CH_MSB 7
`define CH_LSB 4
`define PD_MSB 3
`define PD_LSB 2
`endif

// ==== inc/edge_if.sv ====
// synchronised pin levels and edge strobes
`timescale 1ns/1ps
interface edge_if;
    logic sck_rise;
    logic sck_fall;
    logic start_rise;
    logic sel_n;
    logic sdi;
    modport src (output sck_rise, output sck_fall, output start_rise, output sel_n, output sdi);
    modport dst (input sck_rise, input sck_fall, input start_rise, input sel_n, input sdi);
endinterface

// ==== verif/adc_port_chk.sv ====
// pin-level checks on the converter serial port
`timescale 1ns/1ps
module adc_port_chk (
    input logic i_ref_clk,
    input logic i_arst_n,
    input logic i_conversion_start_pin,
    input logic i_sel_n,
    input logic i_sck,
    input adc_port_pkg::result_t i_sample,
    input logic o_busy_n,
    input logic o_sdo,
    input logic o_sdo_oe,
    input logic o_acquiring,
    input adc_port_pkg::cfg_t o_cfg,
    input logic o_sample_take
);
    import adc_port_pkg::*;
    logic [7:0] low_ff;
    logic [7:0] nxt_low;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    // length of the busy-low span, so an exact figure can be asserted
    always_comb nxt_low = o_busy_n ? 8'h00 : low_ff + 8'h01;
    always_ff @(posedge i_ref_clk or negedge i_arst_n)
        if (!i_arst_n) low_ff <= 8'h00;
        else low_ff <= nxt_low;
    property p_start; $rose(i_conversion_start_pin) && o_busy_n |-> ##[2:5] !o_busy_n; endproperty
    a_start: assert property (p_start) else $error("start missed");
    property p_busy; $rose(o_busy_n) |-> low_ff == 8'h64; endproperty
    a_busy: assert property (p_busy) else $error("busy length");
    property p_take; o_sample_take |-> $fell(o_busy_n); endproperty
    a_take: assert property (p_take) else $error("restarted");
    property p_oe; i_sel_n [*6] |-> !o_sdo_oe; endproperty
    a_oe: assert property (p_oe) else $error("sdo driven");
    property p_quiet; i_sel_n [*6] |=> $stable(o_cfg); endproperty
    a_quiet: assert property (p_quiet) else $error("cfg moved");
    property p_acq; $rose(i_conversion_start_pin) && o_acquiring |-> ##[2:5] !o_acquiring; endproperty
    a_acq: assert property (p_acq) else $error("acq held");
    property p_load; $rose(o_busy_n) |-> o_sdo == i_sample[15]; endproperty
    a_load: assert property (p_load) else $error("msb not loaded");
    property p_shift; $changed(o_sdo) && !$rose(o_busy_n) |-> $past(i_sck, 5) && !$past(i_sck, 2); endproperty
    a_shift: assert property (p_shift) else $error("sdo moved");
endmodule

// ==== verif/host_model.sv ====
// host side of the serial link
`timescale 1ns/1ps
module host_model (
    input wire logic i_clk,
    input wire logic i_sdo,
    output logic o_sel_n,
    output logic o_sck,
    output logic o_sdi
);
    initial o_sel_n = 1'b1;
    initial o_sck = 1'b0;
    initial o_sdi = 1'b0;
    // sck half period 4 clk, still between frames
    task automatic frame(input logic en, input int n, input logic [15:0] w, output logic [15:0] r);
        r = 16'h0000;
        o_sel_n <= ~en;
        repeat (4) @(posedge i_clk);
        for (int i = 0; i < n; i++) begin
            o_sdi <= w[15 - i];
            repeat (4) @(posedge i_clk);
            o_sck <= 1'b1;
            repeat (4) @(posedge i_clk);
            r = {r[14:0], i_sdo};
            o_sck <= 1'b0;
        end
        repeat (4) @(posedge i_clk);
        o_sel_n <= 1'b1;
        o_sdi <= ~o_sdi;
    endtask
endmodule

// ==== verif/tb.sv ====
// self-checking bench for the converter serial port
`timescale 1ns/1ps
module tb;
    import adc_port_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_conversion_start_pin = 1'b0;
    result_t i_sample = 16'h0000;
    logic i_sel_n, i_sck, i_sdi, o_busy_n, o_sdo, o_sdo_oe, o_acquiring, o_sample_take;
    cfg_t o_cfg, c;
    logic [15:0] r, obs, q[$];
    logic [31:0] seed = 32'h1573;
    int mismatches = 0;
    int checks = 0;
    event ev;
    wire sdo_w = o_sdo_oe ? o_sdo : ~o_sdo; // released line never shows a stale bit
    always #25 i_ref_clk = ~i_ref_clk;
    adc_serial_port uut (.*);
    host_model hm (.i_clk(i_ref_clk), .i_sdo(sdo_w), .o_sel_n(i_sel_n), .o_sck(i_sck), .o_sdi(i_sdi));
    function automatic void xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
    endfunction
    task automatic tk(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    task automatic go();
        i_conversion_start_pin <= 1'b1;
        tk(2);
        i_conversion_start_pin <= 1'b0;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic note(input logic [15:0] exp, input logic [15:0] got);
        q.push_back(exp);
        obs = got;
        ->ev;
        #1;
    endtask
    always @(ev) chk(obs, q.pop_front());
    task automatic stop_test();
        if (mismatches == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        tk(3000);
        mismatches++;
        stop_test();
    end
    initial begin
        tk(4);
        i_arst_n <= 1'b1;
        note(16'h0200, {6'h00, o_busy_n, o_sdo_oe, o_cfg});
        tk(3);
        for (int k = 0; k < 3; k++) begin
            xs();
            c = seed[7:0];
            i_sample <= seed[31:16];
            hm.frame(1'b1, 8, {c, 8'h00}, r);
            tk(6);
            note({8'h00, c}, {8'h00, o_cfg});
            note(16'h0001, {15'h0000, o_acquiring});
            tk(1);
            go();
            tk(20);
            go();
            note(16'h0000, {15'h0000, o_busy_n | o_acquiring});
            tk(90);
            note(16'h0001, {15'h0000, o_busy_n});
            tk(1);
            // the read frame also clocks in the next word, so resend the same one
            hm.frame(1'b1, 16, {c, 8'h00}, r);
            note(i_sample, r);
            tk(1);
            hm.frame(1'b0, 8, ~{c, 8'h00}, r);
            tk(6);
            note({8'h00, c}, {8'h00, o_cfg});
            tk(1);
        end
        stop_test();
    end
endmodule
bind adc_serial_port adc_port_chk chk (.*);
